// ==== core/ccts_pkg.sv ====
/*
 * Constants and types for the clocked serial transfer sequencer:
 * register offsets, field positions, reset values and the state record.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package ccts_pkg;
	localparam int CCTS_AW = 8;
	localparam logic [7:0] CCTS_OFF_MODE = 8'h00;
	localparam logic [7:0] CCTS_OFF_CLKSEL = 8'h04;
	localparam logic [7:0] CCTS_OFF_LEN = 8'h08;
	localparam logic [7:0] CCTS_OFF_STATUS = 8'h0c;
	localparam logic [7:0] CCTS_OFF_TX = 8'h10;
	localparam logic [7:0] CCTS_OFF_RX = 8'h14;
	// Mode control register fields.
	localparam int CCTS_B_PWR = 7;
	localparam int CCTS_B_TXE = 6;
	localparam int CCTS_B_RXE = 5;
	localparam int CCTS_B_DIR = 4;
	localparam int CCTS_B_CONT = 1;
	localparam int CCTS_B_SCE = 0;
	// Status register fields.
	localparam int CCTS_B_BUSY = 7;
	localparam int CCTS_B_OVE = 0;
	// Clock select: source field width, external clock code.
	localparam int CCTS_CKS_W = 3;
	localparam logic [2:0] CCTS_CKS_EXT = 3'h7;
	localparam logic [3:0] CCTS_LEN_FULL = 4'h0;
	localparam logic [3:0] CCTS_LEN_MAX = 4'h8;
	localparam logic [7:0] CCTS_MODE_RST = 8'h00;
	localparam logic [7:0] CCTS_CLKSEL_RST = 8'h00;
	localparam logic [3:0] CCTS_LENREG_RST = 4'h0;
	localparam int CCTS_DIV_W = 7;

	typedef enum logic [0:0] {CCTS_IDLE, CCTS_RUN} ccts_st_e;

	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] clksel;
		logic [3:0] len;
		logic [7:0] txb;
		logic txf;
		logic [7:0] sh;
		logic [7:0] rxb;
		logic rxf;
		logic busy;
		logic ove;
		logic [3:0] cnt;
		logic sck;
		logic sck_prev;
		logic so;
		ccts_st_e st;
		logic rdone;
		logic tready;
		logic [31:0] rdata;
		logic wpend;
		logic [CCTS_AW-1:0] waddr;
	} ccts_state_s;

	localparam ccts_state_s CCTS_STATE_RST = '{
		mode: CCTS_MODE_RST, clksel: CCTS_CLKSEL_RST,
		len: CCTS_LENREG_RST, sck: 1'b1, sck_prev: 1'b1, so: 1'b1,
		st: CCTS_IDLE, default: '0};
endpackage

// ==== core/ccts_rate_div.sv ====
/*
 * Half-period enable for the master serial clock: one pulse every
 * 2**sel cycles while run is high, so the serial clock is clk_sys/2**(sel+1).
 * Assumes run drops between transfers so each transfer starts phase aligned.
 */
`timescale 1ns/10ps
module ccts_rate_div
	import ccts_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic run,
	input wire logic [CCTS_CKS_W-1:0] sel,
	output logic tick
);
	typedef struct packed {
		logic [CCTS_DIV_W-1:0] cnt;
	} ccts_div_s;

	ccts_div_s q;
	ccts_div_s d;
	logic [CCTS_DIV_W-1:0] limit;

	always_comb begin
		limit = CCTS_DIV_W'((1 << sel) - 1);
		d = q;
		tick = run && (q.cnt == limit);
		if (!run || tick) begin
			d.cnt = '0;
		end else begin
			d.cnt = q.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

// ==== core/ccts_core.sv ====
/*
 * Clocked serial transfer sequencer: AHB-Lite register slave, transfer
 * control and shift engine for type 1 clocking (idle high, data changes
 * on the falling edge, sampled on the rising edge).
 * Assumes the serial clock and data inputs are synchronous to clk_sys.
 */
`timescale 1ns/10ps
module ccts_core
	import ccts_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [CCTS_AW-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	output logic serial_out_pin,
	input wire logic serial_in_pin,
	output logic receive_done_irq,
	output logic transmit_ready_irq
);
	ccts_state_s q;
	ccts_state_s d;
	logic pwr, txe, rxe, cont, sce, lsb, master;
	logic aphase, rd_rx, tick, fall, rise, done, again;
	logic [3:0] nbits;
	logic [7:0] shifted;

	// Zero selects the full eight bits; larger codes clamp to the shifter.
	function automatic logic [3:0] len_of(input logic [3:0] f);
		if (f == CCTS_LEN_FULL || f > CCTS_LEN_MAX) begin
			return CCTS_LEN_MAX;
		end
		return f;
	endfunction

	function automatic logic out_bit(input logic [7:0] sh,
			input logic [3:0] n, input logic lsb_first);
		if (lsb_first) begin
			return sh[0];
		end
		return sh[3'(n - 4'h1)];
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] sh,
			input logic [3:0] n, input logic lsb_first, input logic b);
		logic [7:0] r;
		r = lsb_first ? (sh >> 1) : (sh << 1);
		if (lsb_first) begin
			r[3'(n - 4'h1)] = b;
		end else begin
			r[0] = b;
		end
		return r;
	endfunction

	ccts_rate_div u_div (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.run(master && pwr && q.st == CCTS_RUN),
		.sel(q.clksel[CCTS_CKS_W-1:0]),
		.tick(tick)
	);

	always_comb begin
		pwr = q.mode[CCTS_B_PWR];
		txe = q.mode[CCTS_B_TXE];
		rxe = q.mode[CCTS_B_RXE];
		cont = q.mode[CCTS_B_CONT];
		sce = q.mode[CCTS_B_SCE];
		lsb = q.mode[CCTS_B_DIR];
		master = q.clksel[CCTS_CKS_W-1:0] != CCTS_CKS_EXT;
		nbits = len_of(q.len);
		aphase = hsel && hready && htrans[1];
		rd_rx = aphase && !hwrite && haddr == CCTS_OFF_RX;
		if (master) begin
			fall = tick && q.sck;
			rise = tick && !q.sck;
		end else begin
			fall = q.sck_prev && !serial_clock_pin_in;
			rise = !q.sck_prev && serial_clock_pin_in;
		end
		fall = fall && q.st == CCTS_RUN;
		rise = rise && q.st == CCTS_RUN;
		shifted = shift_in(q.sh, nbits, lsb, serial_in_pin);
		done = rise && (q.cnt + 4'h1 == nbits);
		again = cont && (txe ? q.txf : sce);

		d = q;
		d.rdone = 1'b0;
		d.tready = 1'b0;
		d.sck_prev = serial_clock_pin_in;
		d.wpend = aphase && hwrite;
		d.waddr = haddr;
		if (aphase && !hwrite) begin
			case (haddr)
				CCTS_OFF_MODE: d.rdata = {24'h0, q.mode};
				CCTS_OFF_CLKSEL: d.rdata = {24'h0, q.clksel};
				CCTS_OFF_LEN: d.rdata = {28'h0, q.len};
				CCTS_OFF_STATUS: d.rdata = {24'h0, q.busy, 6'h0, q.ove};
				CCTS_OFF_TX: d.rdata = {24'h0, q.txb};
				CCTS_OFF_RX: d.rdata = {24'h0, q.rxb};
				default: d.rdata = 32'h0;
			endcase
		end

		// Clears from the bus come before the engine so a set wins.
		if (q.wpend) begin
			case (q.waddr)
				CCTS_OFF_MODE: d.mode = hwdata[7:0];
				CCTS_OFF_CLKSEL: d.clksel = hwdata[7:0];
				CCTS_OFF_LEN: d.len = hwdata[3:0];
				CCTS_OFF_STATUS: begin
					if (!hwdata[CCTS_B_OVE]) begin
						d.ove = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (rd_rx) begin
			d.rxf = 1'b0;
			if (pwr && rxe && !txe && sce && !q.busy) begin
				d.busy = 1'b1;
			end
		end

		case (q.st)
			CCTS_IDLE: begin
				if (q.busy && pwr) begin
					if (txe && q.txf) begin
						d.sh = q.txb;
						d.txf = 1'b0;
						d.tready = cont;
						d.cnt = 4'h0;
						d.st = CCTS_RUN;
					end else if (rxe && !txe) begin
						d.cnt = 4'h0;
						d.st = CCTS_RUN;
					end
				end
			end
			CCTS_RUN: begin
				if (master && tick) begin
					d.sck = ~q.sck;
				end
				if (fall && txe) begin
					d.so = out_bit(q.sh, nbits, lsb);
				end
				if (rise) begin
					d.sh = shifted;
					d.cnt = q.cnt + 4'h1;
				end
				if (done) begin
					d.st = CCTS_IDLE;
					if (rxe) begin
						if (d.rxf) begin
							d.ove = 1'b1;
						end
						d.rxb = shifted;
						d.rxf = 1'b1;
					end
					// Transmit-only continuous mode reports only readiness.
					d.rdone = !(cont && txe && !rxe);
					if (!again) begin
						d.busy = 1'b0;
					end
				end
			end
			default: d.st = CCTS_IDLE;
		endcase

		// A transmit write after the engine so a load in the same cycle
		// does not swallow the new word.
		if (q.wpend && q.waddr == CCTS_OFF_TX && pwr && txe) begin
			d.txb = hwdata[7:0];
			d.txf = 1'b1;
			d.busy = 1'b1;
		end
		if (!pwr) begin
			d.busy = 1'b0;
			d.txf = 1'b0;
			d.st = CCTS_IDLE;
			d.sck = 1'b1;
			d.cnt = 4'h0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			q <= CCTS_STATE_RST;
		end else begin
			q <= d;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = q.rdata;
	assign serial_clock_pin_out = q.sck;
	assign serial_clock_pin_oe = pwr && master;
	assign serial_out_pin = q.so;
	assign receive_done_irq = q.rdone;
	assign transmit_ready_irq = q.tready;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	sequence rx_dummy_read_s;
		rd_rx && pwr && rxe && !txe && sce && !q.busy;
	endsequence

	sequence tx_write_s;
		q.wpend && q.waddr == CCTS_OFF_TX && pwr && txe;
	endsequence

	sequence single_done_s;
		done && !cont && pwr;
	endsequence

	rx_start_a: assert property (rx_dummy_read_s |=> q.busy ##1
		q.st == CCTS_RUN)
		else $error("dummy read did not start reception");

	tx_start_a: assert property (tx_write_s |=> q.busy && q.txf)
		else $error("transmit write did not start transfer");

	master_clk_a: assert property (q.st == CCTS_RUN && master && pwr
		|-> serial_clock_pin_oe ##1 ($stable(q.sck) || tick ||
		$past(tick)))
		else $error("master serial clock not driven");

	slave_edge_a: assert property (!master && rise && !done
		|=> q.cnt == $past(q.cnt) + 4'h1)
		else $error("slave edge not counted");

	single_done_a: assert property (single_done_s
		|=> receive_done_irq && !q.busy && q.st == CCTS_IDLE)
		else $error("single transfer did not finish cleanly");

	no_rdone_a: assert property (cont && txe && !rxe
		|=> !receive_done_irq || $past(q.mode) != q.mode)
		else $error("receive done in transmit-only continuous mode");

	no_tready_a: assert property (!cont && $stable(q.mode)
		|=> !transmit_ready_irq)
		else $error("transmit ready in single mode");

	cont_next_a: assert property (done && cont && txe && q.txf && pwr
		|=> q.busy ##1 q.st == CCTS_RUN)
		else $error("pending word did not follow");

	cont_stop_a: assert property (done && cont && !again && pwr
		&& !(q.wpend && q.waddr == CCTS_OFF_TX)
		|=> !q.busy [*2])
		else $error("continuous mode did not stop");

	ove_hold_a: assert property (q.ove && !(q.wpend &&
		q.waddr == CCTS_OFF_STATUS && !hwdata[CCTS_B_OVE]) |=> q.ove)
		else $error("overrun flag lost");

	ove_irq_a: assert property (done && rxe && q.rxf && !rd_rx
		|=> q.ove && receive_done_irq)
		else $error("overrun without receive done");
endmodule

// ==== test/ccts_peer.sv ====
/*
 * Behavioural serial peer for the sequencer: type 1 timing, data MSB first.
 * Assumes the bench resolves the shared clock wire and passes it in as sck.
 */
`timescale 1ns/10ps
module ccts_peer (
	input wire logic clk_sys,
	input wire logic sck,
	input wire logic so,
	output logic si,
	output logic sck_drv
);
	logic [15:0] sh = '0;
	logic [15:0] rx = '0;
	logic [2:0] nb = '0;
	logic act = 1'b0;
	logic bq = 1'b1;
	logic idl = 1'b0;
	initial sck_drv = 1'b1;
	// Outside a frame the line is released, so it toggles every cycle.
	assign si = act ? bq : idl;
	always @(posedge clk_sys) begin
		idl <= ~idl;
	end
	always @(negedge sck) begin
		act <= 1'b1;
		bq <= sh[15];
		sh <= {sh[14:0], 1'b0};
	end
	always @(posedge sck) begin
		if (act) begin
			rx <= {rx[14:0], so};
			nb <= nb + 3'h1;
			if (nb == 3'h7)
				act <= 1'b0;
		end
	end
	task automatic load(input logic [15:0] d);
		sh = d;
		rx = '0;
	endtask
	// Slave clock: eight periods, four system cycles per half period.
	task automatic frame();
		repeat (8) begin
			sck_drv <= 1'b0;
			repeat (4) @(posedge clk_sys);
			sck_drv <= 1'b1;
			repeat (4) @(posedge clk_sys);
		end
	endtask
endmodule

// ==== test/clocked_serial_transfer_sequencer_tb_top.sv ====
/*
 * Self-checking bench for ccts_core: AHB-Lite register tasks and a serial
 * peer. Assumes zero-wait-state bus answers may still be stretched.
 */
`timescale 1ns/10ps
module clocked_serial_transfer_sequencer_tb_top
	import ccts_pkg::*;
;
	logic clk_sys, rst_b, hsel, hwrite, hreadyout, hresp;
	logic [CCTS_AW-1:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, v;
	logic sck_out, sck_oe, sck_drv, sck_w, so, si, rd_irq, tr_irq;
	int n_mismatch, tests_run, nrd, ntr;
	assign sck_w = sck_oe ? sck_out : sck_drv;
	ccts_core u_dut(.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .serial_clock_pin_in(sck_w),
		.serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe),
		.serial_out_pin(so), .serial_in_pin(si),
		.receive_done_irq(rd_irq), .transmit_ready_irq(tr_irq));
	ccts_peer u_peer(.clk_sys(clk_sys), .sck(sck_w), .so(so), .si(si),
		.sck_drv(sck_drv));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (rd_irq === 1'b1)
			nrd++;
		if (tr_irq === 1'b1)
			ntr++;
	end
	task automatic report_and_stop();
		if (n_mismatch == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [CCTS_AW-1:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		v = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic wr(input logic [CCTS_AW-1:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [CCTS_AW-1:0] a, input logic [31:0] e,
		input string nm);
		bus(1'b0, a, 32'h0);
		chk(nm, e, v);
	endtask
	task automatic wait_n(input int t);
		for (int i = 0; i < 400 && nrd < t; i++) @(posedge clk_sys);
		chk("done count", t, nrd);
	endtask
	task automatic wait_idle();
		v = 32'h80;
		for (int i = 0; i < 100 && v[7]; i++) bus(1'b0, CCTS_OFF_STATUS, 0);
		chk("busy", 32'h0, {24'h0, v[7], 7'h0});
	endtask
	initial begin
		#100us;
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		rst_b = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = '0;
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		rd(CCTS_OFF_MODE, 32'h0, "mode");
		rd(CCTS_OFF_CLKSEL, 32'h0, "clksel");
		rd(CCTS_OFF_STATUS, 32'h0, "status");
		wr(8'h1c, 32'hff);
		rd(8'h1c, 32'h0, "unmapped");
		// Master single exchange at the fastest internal rate.
		wr(CCTS_OFF_CLKSEL, 32'h00);
		wr(CCTS_OFF_LEN, 32'h00);
		wr(CCTS_OFF_MODE, 32'he1);
		u_peer.load(16'h3c00);
		wr(CCTS_OFF_TX, 32'ha5);
		rd(CCTS_OFF_STATUS, 32'h80, "status");
		wait_n(1);
		chk("peer rx", 32'ha5, {16'h0, u_peer.rx});
		rd(CCTS_OFF_RX, 32'h3c, "rx");
		rd(CCTS_OFF_STATUS, 32'h0, "status");
		// Master single receive, restarted by reading with SCE set and continuous mode off.
		wr(CCTS_OFF_MODE, 32'ha1);
		u_peer.load(16'h5ac3);
		bus(1'b0, CCTS_OFF_RX, 32'h0);
		rd(CCTS_OFF_STATUS, 32'h80, "status");
		wait_n(2);
		rd(CCTS_OFF_RX, 32'h5a, "rx");
		wait_n(3);
		wr(CCTS_OFF_MODE, 32'ha0);
		rd(CCTS_OFF_RX, 32'hc3, "rx");
		repeat (40) @(posedge clk_sys);
		chk("done count", 3, nrd);
		chk("tx ready", 0, ntr);
		// Continuous transmit with a second word queued early.
		wr(CCTS_OFF_MODE, 32'hc3);
		u_peer.load(16'h0);
		wr(CCTS_OFF_TX, 32'h81);
		wr(CCTS_OFF_TX, 32'h7e);
		wait_idle();
		chk("peer rx", 32'h817e, {16'h0, u_peer.rx});
		chk("tx ready", 2, ntr);
		chk("done count", 3, nrd);
		// Continuous receive, left unread so the second word overruns.
		u_peer.load(16'h1122);
		wr(CCTS_OFF_MODE, 32'ha3);
		bus(1'b0, CCTS_OFF_RX, 32'h0);
		wait_n(4);
		wr(CCTS_OFF_MODE, 32'ha2);
		wait_idle();
		chk("done count", 5, nrd);
		rd(CCTS_OFF_STATUS, 32'h1, "status");
		rd(CCTS_OFF_RX, 32'h22, "rx");
		wr(CCTS_OFF_STATUS, 32'h1);
		rd(CCTS_OFF_STATUS, 32'h1, "status");
		wr(CCTS_OFF_STATUS, 32'h0);
		rd(CCTS_OFF_STATUS, 32'h0, "status");
		// Slave exchange: nothing moves until the peer clocks it.
		wr(CCTS_OFF_MODE, 32'h00);
		wr(CCTS_OFF_CLKSEL, 32'h07);
		wr(CCTS_OFF_MODE, 32'he1);
		chk("clock enable", 32'h0, {31'h0, sck_oe});
		u_peer.load(16'h9600);
		wr(CCTS_OFF_TX, 32'h4b);
		repeat (30) @(posedge clk_sys);
		rd(CCTS_OFF_STATUS, 32'h80, "status");
		u_peer.frame();
		wait_n(6);
		chk("peer rx", 32'h4b, {16'h0, u_peer.rx});
		rd(CCTS_OFF_RX, 32'h96, "rx");
		// Master exchange with the order select set: bits come out reversed.
		wr(CCTS_OFF_MODE, 32'h00);
		wr(CCTS_OFF_CLKSEL, 32'h00);
		wr(CCTS_OFF_MODE, 32'hf1);
		u_peer.load(16'h8000);
		wr(CCTS_OFF_TX, 32'h01);
		wait_n(7);
		chk("peer rx", 32'h80, {16'h0, u_peer.rx});
		rd(CCTS_OFF_RX, 32'h01, "rx");
		report_and_stop();
	end
endmodule
